// ===== inc/tws_pkg.sv
// constants and state codes for the two-wire register access slave
package tws_pkg;
  // --------------------------------------------------------------------
  // addresses and field layout
  // --------------------------------------------------------------------
  localparam logic [6:0] TWS_ADDR_DEFAULT = 7'h10; // bytes 0x20/0x21
  localparam logic [6:0] TWS_ADDR_ALT = 7'h18; // bytes 0x30/0x31
  localparam logic TWS_DIR_READ = 1'h1;
  localparam int TWS_REG_AW = 16;
  localparam int TWS_DW = 8;
  localparam logic [3:0] TWS_BYTE_BITS = 4'h8;
  localparam int TWS_SYNC_W = 4;
  // --------------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------------
  localparam logic [15:0] TWS_PTR_RST = 16'h0000;
  localparam logic [7:0] TWS_BYTE_RST = 8'h00;
  localparam logic [3:0] TWS_CNT_RST = 4'h0;
  localparam logic [3:0] TWS_SYNC_RST = 4'hF;
  // --------------------------------------------------------------------
  // transaction states
  // --------------------------------------------------------------------
  typedef enum logic [3:0] {
    TWS_ST_IDLE = 4'b0000,
    TWS_ST_DEV_ADDR = 4'b0001,
    TWS_ST_DEV_ACK = 4'b0010,
    TWS_ST_ADDR_HI = 4'b0011,
    TWS_ST_HI_ACK = 4'b0100,
    TWS_ST_ADDR_LO = 4'b0101,
    TWS_ST_LO_ACK = 4'b0110,
    TWS_ST_WR_DATA = 4'b0111,
    TWS_ST_WR_ACK = 4'b1000,
    TWS_ST_RD_DATA = 4'b1001,
    TWS_ST_RD_ACK = 4'b1010
  } tws_state_t;
endpackage : tws_pkg

// ===== core/tws_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module tws_sync #(
  parameter int W = tws_pkg::TWS_SYNC_W
) (
  input wire logic clk, // system clock
  input wire logic reset_n, // synchronous reset
  input wire logic [W-1:0] async_in, // pins from outside the domain
  output logic [W-1:0] sync_out // synchronised levels
);
  import tws_pkg::*;
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  // ----------------------------------------------------------------------
  // two stages
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      meta_reg <= W'(TWS_SYNC_RST);
      sync_reg <= W'(TWS_SYNC_RST);
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end
  assign sync_out = sync_reg;
endmodule : tws_sync

// ===== core/tws_cond.sv
// bus condition and clock edge detector on synchronised lines
`timescale 1ns/10ps
module tws_cond (
  input wire logic clk, // system clock
  input wire logic reset_n, // synchronous reset
  input wire logic scl_s, // synchronised clock line
  input wire logic sda_s, // synchronised data line
  output logic scl_rise, // clock line rose
  output logic scl_fall, // clock line fell
  output logic start_det, // data fell while clock high
  output logic stop_det // data rose while clock high
);
  import tws_pkg::*;
  logic scl_d_reg;
  logic sda_d_reg;
  // ----------------------------------------------------------------------
  // previous sample
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end
  assign scl_rise = scl_s && !scl_d_reg;
  assign scl_fall = !scl_s && scl_d_reg;
  assign start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
  assign stop_det = scl_s && scl_d_reg && !sda_d_reg && sda_s;
endmodule : tws_cond

// ===== core/tws_slave.sv
// two-wire register access slave, transaction logic
`timescale 1ns/10ps
// ------------------------------------------------------------------------
// What this block does
// RULE1: data line left high in ack slot is a not-acknowledge; ends reads.
// RULE2: master opens with start, then address byte; last bit 0 write, 1 read.
// RULE3: acknowledge the address byte only when seven bits match own address.
// RULE4: write header carries 16-bit register address as two acked bytes.
// RULE5: master sends register address upper byte first, lower second.
// RULE6: write data bytes each acknowledged; ended by repeated start or stop.
// RULE7: random read loads pointer by write header, then restart and read.
// RULE8: pointer advances by one after every data byte.
// RULE9: master acknowledges a read byte when it wants another.
// RULE10: stop supplying read data after not-acknowledge; master then stops.
// RULE11: read without address phase returns data at current pointer.
// RULE12: sequential reads continue while master acknowledges each byte.
// RULE13: sequential writes continue, each byte acknowledged, until stop.
// RULE14: answer to 0x20/0x21, or 0x30/0x31 when select enabled and high.
// RULE15: bytes go msb first, then an ack slot driven low by receiver.
// RULE16: pointer kept across stop and repeated start.
// RULE17: successive write bytes go to successive pointer addresses.
// ------------------------------------------------------------------------
module tws_slave (
  input wire logic clk, // 20 MHz system clock
  input wire logic reset_n, // synchronous reset, active low
  input wire logic serial_clock_line_in, // clock line pin level
  input wire logic serial_data_line_in, // data line pin level
  output logic serial_data_line_out, // data line drive value
  output logic serial_data_line_oe, // high while pulling data line
  input wire logic address_select_input, // alternate address pin
  input wire logic address_select_enable, // enables the select pin
  output logic [tws_pkg::TWS_REG_AW-1:0] reg_addr, // register address
  output logic [tws_pkg::TWS_DW-1:0] wr_data, // register write data
  output logic wr_strobe, // one-cycle write pulse
  output logic rd_strobe, // one-cycle read request pulse
  input wire logic [tws_pkg::TWS_DW-1:0] rd_data // read data from regs
);
  import tws_pkg::*;
  // ----------------------------------------------------------------------
  // pin synchronisation and edge detection
  // ----------------------------------------------------------------------
  logic [TWS_SYNC_W-1:0] pins_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic sda_s;
  logic [6:0] own_addr;
  tws_sync #(.W(TWS_SYNC_W)) u_tws_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in({address_select_enable, address_select_input,
      serial_data_line_in, serial_clock_line_in}),
    .sync_out(pins_s)
  );
  tws_cond u_tws_cond (
    .clk(clk),
    .reset_n(reset_n),
    .scl_s(pins_s[0]),
    .sda_s(pins_s[1]),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_det(start_det),
    .stop_det(stop_det)
  );
  assign sda_s = pins_s[1];
  // alternate address only when the select pin is both enabled and high
  assign own_addr = (pins_s[3] && pins_s[2]) ? TWS_ADDR_ALT
    : TWS_ADDR_DEFAULT; // [RULE14]
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  tws_state_t state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] hi_reg, hi_next;
  logic [15:0] ptr_reg, ptr_next;
  logic rw_reg, rw_next;
  logic oe_reg, oe_next;
  logic [15:0] addr_reg, addr_next;
  logic [7:0] wdat_reg, wdat_next;
  logic wstb_reg, wstb_next;
  logic rstb_reg, rstb_next;
  // ----------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    hi_next = hi_reg;
    ptr_next = ptr_reg;
    rw_next = rw_reg;
    oe_next = oe_reg;
    addr_next = addr_reg;
    wdat_next = wdat_reg;
    wstb_next = 1'b0;
    rstb_next = 1'b0;
    if (stop_det) begin
      // pointer is left alone so later reads continue from it
      state_next = TWS_ST_IDLE; // [RULE16]
      oe_next = 1'b0;
    end else if (start_det) begin
      state_next = TWS_ST_DEV_ADDR; // [RULE2] [RULE6] [RULE16]
      cnt_next = TWS_CNT_RST;
      oe_next = 1'b0;
    end else if (scl_rise) begin
      case (state_reg)
        TWS_ST_DEV_ADDR, TWS_ST_ADDR_HI, TWS_ST_ADDR_LO,
        TWS_ST_WR_DATA: begin
          shift_next = {shift_reg[6:0], sda_s}; // [RULE15]
          cnt_next = cnt_reg + 4'h1;
        end
        TWS_ST_DEV_ACK: begin
          if (rw_reg == TWS_DIR_READ) begin
            rstb_next = 1'b1; // [RULE11]
            addr_next = ptr_reg;
          end
        end
        TWS_ST_RD_DATA: begin
          cnt_next = cnt_reg + 4'h1;
        end
        TWS_ST_RD_ACK: begin
          if (!sda_s) begin
            rstb_next = 1'b1; // [RULE9] [RULE12]
            addr_next = ptr_reg;
          end else begin
            state_next = TWS_ST_IDLE; // [RULE1] [RULE10]
          end
        end
        default: begin
          cnt_next = cnt_reg;
        end
      endcase
    end else if (scl_fall) begin
      case (state_reg)
        TWS_ST_DEV_ADDR: begin
          if (cnt_reg == TWS_BYTE_BITS) begin
            if (shift_reg[7:1] == own_addr) begin
              oe_next = 1'b1; // [RULE3]
              rw_next = shift_reg[0]; // [RULE2]
              state_next = TWS_ST_DEV_ACK;
            end else begin
              state_next = TWS_ST_IDLE; // [RULE3]
            end
          end
        end
        TWS_ST_DEV_ACK, TWS_ST_RD_ACK: begin
          cnt_next = TWS_CNT_RST;
          if (rw_reg == TWS_DIR_READ) begin
            state_next = TWS_ST_RD_DATA;
            shift_next = rd_data;
            oe_next = !rd_data[7]; // [RULE15]
          end else begin
            state_next = TWS_ST_ADDR_HI;
            oe_next = 1'b0;
          end
        end
        TWS_ST_ADDR_HI: begin
          if (cnt_reg == TWS_BYTE_BITS) begin
            hi_next = shift_reg; // [RULE5]
            oe_next = 1'b1; // [RULE4]
            state_next = TWS_ST_HI_ACK;
          end
        end
        TWS_ST_HI_ACK: begin
          oe_next = 1'b0;
          cnt_next = TWS_CNT_RST;
          state_next = TWS_ST_ADDR_LO;
        end
        TWS_ST_ADDR_LO: begin
          if (cnt_reg == TWS_BYTE_BITS) begin
            ptr_next = {hi_reg, shift_reg}; // [RULE7]
            oe_next = 1'b1; // [RULE4]
            state_next = TWS_ST_LO_ACK;
          end
        end
        TWS_ST_LO_ACK, TWS_ST_WR_ACK: begin
          oe_next = 1'b0;
          cnt_next = TWS_CNT_RST;
          state_next = TWS_ST_WR_DATA;
        end
        TWS_ST_WR_DATA: begin
          if (cnt_reg == TWS_BYTE_BITS) begin
            wstb_next = 1'b1; // [RULE6] [RULE13]
            addr_next = ptr_reg;
            wdat_next = shift_reg;
            ptr_next = ptr_reg + 16'h0001; // [RULE8] [RULE17]
            oe_next = 1'b1;
            state_next = TWS_ST_WR_ACK;
          end
        end
        TWS_ST_RD_DATA: begin
          if (cnt_reg == TWS_BYTE_BITS) begin
            // release for the master's answer, pointer moves on
            oe_next = 1'b0;
            ptr_next = ptr_reg + 16'h0001; // [RULE8]
            state_next = TWS_ST_RD_ACK;
          end else begin
            shift_next = {shift_reg[6:0], 1'b0};
            oe_next = !shift_reg[6]; // [RULE15]
          end
        end
        default: begin
          oe_next = 1'b0;
        end
      endcase
    end
  end
  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= TWS_ST_IDLE;
      cnt_reg <= TWS_CNT_RST;
      shift_reg <= TWS_BYTE_RST;
      hi_reg <= TWS_BYTE_RST;
      ptr_reg <= TWS_PTR_RST;
      rw_reg <= 1'b0;
      oe_reg <= 1'b0;
      addr_reg <= TWS_PTR_RST;
      wdat_reg <= TWS_BYTE_RST;
      wstb_reg <= 1'b0;
      rstb_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      hi_reg <= hi_next;
      ptr_reg <= ptr_next;
      rw_reg <= rw_next;
      oe_reg <= oe_next;
      addr_reg <= addr_next;
      wdat_reg <= wdat_next;
      wstb_reg <= wstb_next;
      rstb_reg <= rstb_next;
    end
  end
  // open drain: the driven value is always low
  assign serial_data_line_out = 1'b0;
  assign serial_data_line_oe = oe_reg;
  assign reg_addr = addr_reg;
  assign wr_data = wdat_reg;
  assign wr_strobe = wstb_reg;
  assign rd_strobe = rstb_reg;
  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_nack_slot_free: assert property ( // [RULE1]
    state_reg == TWS_ST_RD_ACK |-> !oe_reg)
    else $error("data line driven during master answer slot");
  chk_addr_match_ack: assert property ( // [RULE3] [RULE14]
    state_reg == TWS_ST_DEV_ACK && $past(state_reg) != TWS_ST_DEV_ACK
    |-> $past(shift_reg[7:1]) == $past(own_addr) && oe_reg)
    else $error("address acknowledged without a match");
  chk_reg_addr_ack: assert property ( // [RULE4]
    state_reg == TWS_ST_HI_ACK || state_reg == TWS_ST_LO_ACK |-> oe_reg)
    else $error("register address byte not acknowledged");
  chk_ptr_load_order: assert property ( // [RULE5] [RULE7]
    state_reg == TWS_ST_LO_ACK && $past(state_reg) == TWS_ST_ADDR_LO
    |-> ptr_reg == {hi_reg, $past(shift_reg)})
    else $error("pointer not loaded high byte first");
  chk_write_advance: assert property ( // [RULE8] [RULE17]
    wstb_reg |-> ptr_reg == addr_reg + 16'h0001 &&
    state_reg == TWS_ST_WR_ACK && oe_reg) // [RULE6] [RULE13]
    else $error("write byte not acked or pointer not advanced");
  chk_read_nack_stop: assert property ( // [RULE10]
    state_reg == TWS_ST_RD_ACK && scl_rise && sda_s && !stop_det &&
    !start_det |=> state_reg == TWS_ST_IDLE ##1 !oe_reg)
    else $error("read continued after not-acknowledge");
  chk_current_read: assert property ( // [RULE11]
    rstb_reg && $past(state_reg) == TWS_ST_DEV_ACK |-> addr_reg == ptr_reg)
    else $error("current read not from pointer");
  chk_read_msb_drive: assert property ( // [RULE15]
    state_reg == TWS_ST_RD_DATA |-> oe_reg == !shift_reg[7])
    else $error("read bit drive does not follow shift msb");
  chk_ptr_kept_stop: assert property ( // [RULE16]
    stop_det || start_det |=> ptr_reg == $past(ptr_reg))
    else $error("pointer changed on stop or start");
  chk_addr_miss_free: assert property ( // [RULE3] [RULE14]
    state_reg == TWS_ST_DEV_ADDR && scl_fall &&
    cnt_reg == TWS_BYTE_BITS && shift_reg[7:1] != own_addr
    |=> state_reg == TWS_ST_IDLE && !oe_reg)
    else $error("foreign address byte was not left alone");
  chk_read_advance: assert property ( // [RULE8]
    state_reg == TWS_ST_RD_ACK && $past(state_reg) == TWS_ST_RD_DATA
    |-> ptr_reg == $past(ptr_reg) + 16'h0001)
    else $error("pointer not advanced after read byte");
  chk_wstb_pulse: assert property ( // [RULE6]
    wstb_reg |=> !wstb_reg)
    else $error("write strobe longer than one cycle");
  cov_write_byte: cover property (wstb_reg);
  cov_read_nack: cover property (
    state_reg == TWS_ST_RD_ACK && scl_rise && sda_s);
  cov_seq_read: cover property (
    rstb_reg && $past(state_reg) == TWS_ST_RD_ACK);
  cov_alt_addr: cover property (
    state_reg == TWS_ST_DEV_ACK && own_addr == TWS_ADDR_ALT);
endmodule : tws_slave

// ===== verif/tws_host_model.sv
// host bus master model that drives the two-wire link
`timescale 1ns/10ps
module tws_host_model (
  input wire logic clk, // system clock
  output logic scl, // clock line, idle high
  output logic sda_pull, // high while the master pulls data low
  input wire logic sda_wire // resolved data line level
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  // one clock period of 8 clk: low 5, high 3; sampled late in high
  task automatic bit_io(input logic b, output logic r);
    wt(1);
    scl <= 1'b0;
    wt(2);
    sda_pull <= ~b;
    wt(3);
    scl <= 1'b1;
    wt(2);
    r = sda_wire;
  endtask : bit_io
  // start or repeated start: data falls while clock high
  task automatic start_cond();
    wt(1);
    scl <= 1'b0;
    wt(2);
    sda_pull <= 1'b0;
    wt(3);
    scl <= 1'b1;
    wt(3);
    sda_pull <= 1'b1;
    wt(2);
  endtask : start_cond
  // stop: data rises while clock high
  task automatic stop_cond();
    wt(1);
    scl <= 1'b0;
    wt(2);
    sda_pull <= 1'b1;
    wt(3);
    scl <= 1'b1;
    wt(3);
    sda_pull <= 1'b0;
    wt(4);
  endtask : stop_cond
  // eight bits msb first, then a released ack slot
  task automatic byte_tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask : byte_tx
  // eight bits in, then ack low for more or nack to end
  task automatic byte_rx(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~ack, r);
  endtask : byte_rx
endmodule : tws_host_model

// ===== verif/tws_slave_tb_top.sv
// self-checking bench for the two-wire register access slave
`timescale 1ns/10ps
module tws_slave_tb_top;
  import tws_pkg::*;
  logic clk, reset_n, scl, sda_pull, sda_wire, sda_out, sda_oe;
  logic sel_in, sel_en, wr_strobe, rd_strobe;
  logic [15:0] reg_addr;
  logic [7:0] wr_data, rd_data;
  logic [7:0] mem [0:65535];
  int error_cnt, num_checks, cyc;
  // --------------------------------------------------------------------
  // link and register side
  // --------------------------------------------------------------------
  assign sda_wire = ~(sda_pull | (sda_oe & ~sda_out));
  tws_slave u_tws_slave (
    .clk(clk), .reset_n(reset_n), .serial_clock_line_in(scl),
    .serial_data_line_in(sda_wire), .serial_data_line_out(sda_out),
    .serial_data_line_oe(sda_oe), .address_select_input(sel_in),
    .address_select_enable(sel_en), .reg_addr(reg_addr),
    .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
    .rd_data(rd_data));
  tws_host_model u_tws_host_model (
    .clk(clk), .scl(scl), .sda_pull(sda_pull), .sda_wire(sda_wire));
  function automatic logic [7:0] seed_val(input logic [15:0] a);
    return a[7:0] ^ a[15:8];
  endfunction : seed_val
  always #25 clk = ~clk;
  always @(posedge clk) begin
    if (wr_strobe === 1'b1)
      mem[reg_addr] <= wr_data;
    if (!reset_n)
      rd_data <= 8'h00;
    else if (rd_strobe === 1'b1)
      rd_data <= mem[reg_addr];
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      error_cnt = error_cnt + 1;
      wrap_up();
    end
  end
  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tx(input logic [7:0] d, input logic exp_ack);
    logic a;
    u_tws_host_model.byte_tx(d, a);
    chk({15'h0000, a}, {15'h0000, exp_ack});
  endtask : tx
  task automatic rx(input logic ack, input logic [7:0] exp);
    logic [7:0] d;
    u_tws_host_model.byte_rx(ack, d);
    chk({8'h00, d}, {8'h00, exp});
  endtask : rx
  task automatic st();
    u_tws_host_model.start_cond();
  endtask : st
  task automatic sp();
    u_tws_host_model.stop_cond();
  endtask : sp
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up
  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  task automatic test_write_burst();
    st();
    tx(8'h20, 1'b1);
    tx(8'h12, 1'b1);
    tx(8'hFE, 1'b1);
    tx(8'hA5, 1'b1);
    tx(8'h5A, 1'b1);
    tx(8'hC3, 1'b1);
    sp();
    chk({8'h00, mem[16'h12FE]}, 16'h00A5);
    chk({8'h00, mem[16'h12FF]}, 16'h005A);
    chk({8'h00, mem[16'h1300]}, 16'h00C3);
    $display("test write_burst done");
  endtask : test_write_burst
  task automatic test_random_read();
    st();
    tx(8'h20, 1'b1);
    tx(8'h12, 1'b1);
    tx(8'hFE, 1'b1);
    st();
    tx(8'h21, 1'b1);
    rx(1'b1, 8'hA5);
    rx(1'b1, 8'h5A);
    rx(1'b0, 8'hC3);
    // the nack is seen one cycle later; no new read request may follow
    u_tws_host_model.wt(2);
    chk({15'h0000, rd_strobe}, 16'h0000);
    chk({15'h0000, sda_oe}, 16'h0000);
    sp();
    $display("test random_read done");
  endtask : test_random_read
  task automatic test_current_read();
    st();
    tx(8'h21, 1'b1);
    rx(1'b0, seed_val(16'h1301));
    sp();
    st();
    tx(8'h21, 1'b1);
    rx(1'b0, seed_val(16'h1302));
    sp();
    $display("test current_read done");
  endtask : test_current_read
  task automatic test_address_select();
    st();
    tx(8'h22, 1'b0);
    sp();
    // select pin high but not enabled: default address still in force
    sel_in <= 1'b1;
    u_tws_host_model.wt(4);
    st();
    tx(8'h30, 1'b0);
    sp();
    sel_en <= 1'b1;
    sel_in <= 1'b1;
    u_tws_host_model.wt(4);
    st();
    tx(8'h30, 1'b1);
    tx(8'h00, 1'b1);
    tx(8'h40, 1'b1);
    tx(8'h99, 1'b1);
    sp();
    chk({8'h00, mem[16'h0040]}, 16'h0099);
    st();
    tx(8'h20, 1'b0);
    sp();
    sel_in <= 1'b0;
    u_tws_host_model.wt(4);
    st();
    tx(8'h21, 1'b1);
    rx(1'b0, seed_val(16'h0041));
    sp();
    $display("test address_select done");
  endtask : test_address_select
  // --------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    sel_in = 1'b0;
    sel_en = 1'b0;
    error_cnt = 0;
    num_checks = 0;
    for (int i = 0; i < 65536; i++) begin
      mem[i] = seed_val(i[15:0]);
    end
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    test_write_burst();
    test_random_read();
    test_current_read();
    test_address_select();
    wrap_up();
  end
endmodule : tws_slave_tb_top
